//--- sib_consts.svh
// Offsets, subaddress limits and reset values of the subbank register block.
`ifndef SIB_CONSTS_SVH
`define SIB_CONSTS_SVH
`define SIB_SP0_PTR_ADDR 8'h38
`define SIB_SP0_DATA_ADDR 8'h39
`define SIB_SP1_PTR_ADDR 8'h48
`define SIB_SP1_DATA_ADDR 8'h49
`define SIB_SP2_PTR_ADDR 8'h34
`define SIB_SP2_DATA_ADDR 8'h35
`define SIB_DMA_PRIO_ADDR 8'h54
`define SIB_DMA_PTR_ADDR 8'h55
`define SIB_DMA_AUTOINC_ADDR 8'h56
`define SIB_DMA_PLAIN_ADDR 8'h57
`define SIB_SP_SUB_GAP 16'h000f
`define SIB_SP_SUB_END 16'h001c
`define SIB_SP_ENABLE_C_SUB 16'h0010
`define SIB_DMA_CH_STRIDE 16'h0005
`define SIB_DMA_SRC_PAGE_SUB 16'h001e
`define SIB_DMA_DST_PAGE_SUB 16'h001f
`define SIB_DMA_ELEM_IDX0_SUB 16'h0020
`define SIB_DMA_FRAME_IDX0_SUB 16'h0022
`define SIB_DMA_RELOAD_SUB 16'h0024
`define SIB_DMA_SUB_END 16'h003e
`define SIB_SP_CTRL1_SUB 16'h0000
`define SIB_SP_CTRL2_SUB 16'h0001
`define SIB_SP_RX_CTRL1_SUB 16'h0002
`define SIB_SP_RX_CTRL2_SUB 16'h0003
`define SIB_SP_TX_CTRL1_SUB 16'h0004
`define SIB_SP_TX_CTRL2_SUB 16'h0005
`define SIB_SP_RATE1_SUB 16'h0006
`define SIB_SP_RATE2_SUB 16'h0007
`define SIB_SP_MULTI1_SUB 16'h0008
`define SIB_SP_MULTI2_SUB 16'h0009
`define SIB_SP_RX_EN_A_SUB 16'h000a
`define SIB_SP_RX_EN_B_SUB 16'h000b
`define SIB_SP_TX_EN_A_SUB 16'h000c
`define SIB_SP_TX_EN_B_SUB 16'h000d
`define SIB_SP_PIN_CTRL_SUB 16'h000e
`define SIB_SP_RX_EN_D_SUB 16'h0011
`define SIB_SP_TX_EN_C_SUB 16'h0012
`define SIB_SP_TX_EN_D_SUB 16'h0013
`define SIB_SP_RX_EN_E_SUB 16'h0014
`define SIB_SP_RX_EN_F_SUB 16'h0015
`define SIB_SP_TX_EN_E_SUB 16'h0016
`define SIB_SP_TX_EN_F_SUB 16'h0017
`define SIB_SP_RX_EN_G_SUB 16'h0018
`define SIB_SP_RX_EN_H_SUB 16'h0019
`define SIB_SP_TX_EN_G_SUB 16'h001a
`define SIB_SP_TX_EN_H_SUB 16'h001b
`define SIB_DMA_CH0_SRC_SUB 16'h0000
`define SIB_DMA_CH0_DST_SUB 16'h0001
`define SIB_DMA_CH0_CNT_SUB 16'h0002
`define SIB_DMA_CH0_SYNC_SUB 16'h0003
`define SIB_DMA_CH0_MODE_SUB 16'h0004
`define SIB_DMA_CH1_SRC_SUB 16'h0005
`define SIB_DMA_CH1_DST_SUB 16'h0006
`define SIB_DMA_CH1_CNT_SUB 16'h0007
`define SIB_DMA_CH1_SYNC_SUB 16'h0008
`define SIB_DMA_CH1_MODE_SUB 16'h0009
`define SIB_DMA_CH2_SRC_SUB 16'h000a
`define SIB_DMA_CH2_DST_SUB 16'h000b
`define SIB_DMA_CH2_CNT_SUB 16'h000c
`define SIB_DMA_CH2_SYNC_SUB 16'h000d
`define SIB_DMA_CH2_MODE_SUB 16'h000e
`define SIB_DMA_CH3_SRC_SUB 16'h000f
`define SIB_DMA_CH3_DST_SUB 16'h0010
`define SIB_DMA_CH3_CNT_SUB 16'h0011
`define SIB_DMA_CH3_SYNC_SUB 16'h0012
`define SIB_DMA_CH3_MODE_SUB 16'h0013
`define SIB_DMA_CH4_SRC_SUB 16'h0014
`define SIB_DMA_CH4_DST_SUB 16'h0015
`define SIB_DMA_CH4_CNT_SUB 16'h0016
`define SIB_DMA_CH4_SYNC_SUB 16'h0017
`define SIB_DMA_CH4_MODE_SUB 16'h0018
`define SIB_DMA_CH5_SRC_SUB 16'h0019
`define SIB_DMA_CH5_DST_SUB 16'h001a
`define SIB_DMA_CH5_CNT_SUB 16'h001b
`define SIB_DMA_CH5_SYNC_SUB 16'h001c
`define SIB_DMA_CH5_MODE_SUB 16'h001d
`define SIB_DMA_ELEM_IDX1_SUB 16'h0021
`define SIB_DMA_FRAME_IDX1_SUB 16'h0023
`define SIB_DMA_RLD0_DST_SUB 16'h0025
`define SIB_DMA_RLD0_CNT_SUB 16'h0026
`define SIB_DMA_RLD0_FRM_SUB 16'h0027
`define SIB_DMA_XSRC_PAGE_SUB 16'h0028
`define SIB_DMA_XDST_PAGE_SUB 16'h0029
`define SIB_DMA_RLD1_SRC_SUB 16'h002a
`define SIB_DMA_RLD1_DST_SUB 16'h002b
`define SIB_DMA_RLD1_CNT_SUB 16'h002c
`define SIB_DMA_RLD1_FRM_SUB 16'h002d
`define SIB_DMA_RLD2_SRC_SUB 16'h002e
`define SIB_DMA_RLD2_DST_SUB 16'h002f
`define SIB_DMA_RLD2_CNT_SUB 16'h0030
`define SIB_DMA_RLD2_FRM_SUB 16'h0031
`define SIB_DMA_RLD3_SRC_SUB 16'h0032
`define SIB_DMA_RLD3_DST_SUB 16'h0033
`define SIB_DMA_RLD3_CNT_SUB 16'h0034
`define SIB_DMA_RLD3_FRM_SUB 16'h0035
`define SIB_DMA_RLD4_SRC_SUB 16'h0036
`define SIB_DMA_RLD4_DST_SUB 16'h0037
`define SIB_DMA_RLD4_CNT_SUB 16'h0038
`define SIB_DMA_RLD4_FRM_SUB 16'h0039
`define SIB_DMA_RLD5_SRC_SUB 16'h003a
`define SIB_DMA_RLD5_DST_SUB 16'h003b
`define SIB_DMA_RLD5_CNT_SUB 16'h003c
`define SIB_DMA_RLD5_FRM_SUB 16'h003d
`define SIB_REG_RESET 16'h0000
`define SIB_PTR_RESET 16'h0000
`endif

//--- sib_pkg.sv
// Types shared by the subbank register block.
`default_nettype none
package sib_pkg;
    localparam int SIB_SP_PORTS = 3;
    localparam int SIB_SP_NREG = 28;
    localparam int SIB_DMA_NREG = 62;

    typedef enum logic [1:0] {
        SIB_PORT0 = 2'h0,
        SIB_PORT1 = 2'h1,
        SIB_PORT2 = 2'h2,
        SIB_PORT_NONE = 2'h3
    } sib_port_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [15:0] wdata;
    } sib_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } sib_rsp_t;

    typedef struct packed {
        logic [SIB_SP_PORTS-1:0][15:0] sp_ptr;
        logic [SIB_SP_PORTS-1:0][SIB_SP_NREG-1:0][15:0] sp_reg;
        logic [15:0] dma_ptr;
        logic [SIB_DMA_NREG-1:0][15:0] dma_reg;
        logic [15:0] dma_prio;
        sib_rsp_t rsp;
    } sib_state_t;
endpackage
`default_nettype wire

//--- sib_regbank.sv
// Subbank indirect access to serial-port and DMA control registers.
// Summary of operation
// - Each serial port's pointer picks which of its control registers its data location reaches.
// - A data-location read returns the selected register and a write updates only that register.
// - Serial ports 0, 1 and 2 have data locations at 39h, 49h and 35h with one common subaddress map.
// - Serial subaddresses 00h to 0Eh hold the fifteen control, rate, multichannel, enable A/B and pin registers in order.
// - Serial subaddresses 010h to 01Bh hold channel-enable partitions C to H, receive pair then transmit pair.
// - The DMA priority and enable register sits directly at its own address, not behind the pointer.
// - The DMA pointer selects the DMA register reached through the data locations at 56h and 57h.
// - Each access through 56h reaches the selected register and then adds one to the DMA pointer.
// - DMA subaddresses 00h to 1Dh hold six channels of five registers, channel n starting at 5n.
// - DMA subaddresses 1Eh and 1Fh hold the shared source and destination program pages.
// - DMA subaddresses 20h to 23h hold element index 0 and 1 and frame index 0 and 1.
// - Serial pointers sit at 38h, 48h and 34h and the DMA pointer at 55h.
// - DMA subaddresses from 24h hold the per-channel reload and extended page registers.
`timescale 1ns/1ps
`default_nettype none
`include "sib_consts.svh"
module sib_regbank (
    input wire logic clk,
    input wire logic rst,
    input wire sib_pkg::sib_req_t req,
    output var sib_pkg::sib_rsp_t rsp,
    output logic [15:0] dma_prio,
    output logic [15:0] dma_ptr
);
    import sib_pkg::*;

    // ==========================================================
    // Address decode.
    // ==========================================================
    function automatic sib_port_t sp_data_sel(input logic [7:0] a);
        if (a == `SIB_SP0_DATA_ADDR) begin
            return SIB_PORT0;
        end else if (a == `SIB_SP1_DATA_ADDR) begin
            return SIB_PORT1;
        end else if (a == `SIB_SP2_DATA_ADDR) begin
            return SIB_PORT2;
        end
        return SIB_PORT_NONE;
    endfunction

    function automatic sib_port_t sp_ptr_sel(input logic [7:0] a);
        if (a == `SIB_SP0_PTR_ADDR) begin
            return SIB_PORT0;
        end else if (a == `SIB_SP1_PTR_ADDR) begin
            return SIB_PORT1;
        end else if (a == `SIB_SP2_PTR_ADDR) begin
            return SIB_PORT2;
        end
        return SIB_PORT_NONE;
    endfunction

    // ==========================================================
    // Subaddress decode.
    // ==========================================================

    // Only the named serial registers hold storage; 0Fh is a hole.
    function automatic logic sp_sub_ok(input logic [15:0] p);
        case (p)
            `SIB_SP_CTRL1_SUB,
            `SIB_SP_CTRL2_SUB,
            `SIB_SP_RX_CTRL1_SUB,
            `SIB_SP_RX_CTRL2_SUB,
            `SIB_SP_TX_CTRL1_SUB,
            `SIB_SP_TX_CTRL2_SUB,
            `SIB_SP_RATE1_SUB,
            `SIB_SP_RATE2_SUB,
            `SIB_SP_MULTI1_SUB,
            `SIB_SP_MULTI2_SUB,
            `SIB_SP_RX_EN_A_SUB,
            `SIB_SP_RX_EN_B_SUB,
            `SIB_SP_TX_EN_A_SUB,
            `SIB_SP_TX_EN_B_SUB,
            `SIB_SP_PIN_CTRL_SUB,
            `SIB_SP_ENABLE_C_SUB,
            `SIB_SP_RX_EN_D_SUB,
            `SIB_SP_TX_EN_C_SUB,
            `SIB_SP_TX_EN_D_SUB,
            `SIB_SP_RX_EN_E_SUB,
            `SIB_SP_RX_EN_F_SUB,
            `SIB_SP_TX_EN_E_SUB,
            `SIB_SP_TX_EN_F_SUB,
            `SIB_SP_RX_EN_G_SUB,
            `SIB_SP_RX_EN_H_SUB,
            `SIB_SP_TX_EN_G_SUB,
            `SIB_SP_TX_EN_H_SUB: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction

    // Serial storage is packed densely, closing the hole at 0Fh.
    function automatic logic [4:0] sp_slot(input logic [15:0] p);
        case (p)
            `SIB_SP_CTRL1_SUB: return 5'h00;
            `SIB_SP_CTRL2_SUB: return 5'h01;
            `SIB_SP_RX_CTRL1_SUB: return 5'h02;
            `SIB_SP_RX_CTRL2_SUB: return 5'h03;
            `SIB_SP_TX_CTRL1_SUB: return 5'h04;
            `SIB_SP_TX_CTRL2_SUB: return 5'h05;
            `SIB_SP_RATE1_SUB: return 5'h06;
            `SIB_SP_RATE2_SUB: return 5'h07;
            `SIB_SP_MULTI1_SUB: return 5'h08;
            `SIB_SP_MULTI2_SUB: return 5'h09;
            `SIB_SP_RX_EN_A_SUB: return 5'h0a;
            `SIB_SP_RX_EN_B_SUB: return 5'h0b;
            `SIB_SP_TX_EN_A_SUB: return 5'h0c;
            `SIB_SP_TX_EN_B_SUB: return 5'h0d;
            `SIB_SP_PIN_CTRL_SUB: return 5'h0e;
            `SIB_SP_ENABLE_C_SUB: return 5'h0f;
            `SIB_SP_RX_EN_D_SUB: return 5'h10;
            `SIB_SP_TX_EN_C_SUB: return 5'h11;
            `SIB_SP_TX_EN_D_SUB: return 5'h12;
            `SIB_SP_RX_EN_E_SUB: return 5'h13;
            `SIB_SP_RX_EN_F_SUB: return 5'h14;
            `SIB_SP_TX_EN_E_SUB: return 5'h15;
            `SIB_SP_TX_EN_F_SUB: return 5'h16;
            `SIB_SP_RX_EN_G_SUB: return 5'h17;
            `SIB_SP_RX_EN_H_SUB: return 5'h18;
            `SIB_SP_TX_EN_G_SUB: return 5'h19;
            `SIB_SP_TX_EN_H_SUB: return 5'h1a;
            default: return 5'h00;
        endcase
    endfunction

    // Channels at 5n, pages, indexes, then reload and extended pages.
    function automatic logic dma_sub_ok(input logic [15:0] p);
        case (p)
            `SIB_DMA_CH0_SRC_SUB,
            `SIB_DMA_CH0_DST_SUB,
            `SIB_DMA_CH0_CNT_SUB,
            `SIB_DMA_CH0_SYNC_SUB,
            `SIB_DMA_CH0_MODE_SUB,
            `SIB_DMA_CH1_SRC_SUB,
            `SIB_DMA_CH1_DST_SUB,
            `SIB_DMA_CH1_CNT_SUB,
            `SIB_DMA_CH1_SYNC_SUB,
            `SIB_DMA_CH1_MODE_SUB,
            `SIB_DMA_CH2_SRC_SUB,
            `SIB_DMA_CH2_DST_SUB,
            `SIB_DMA_CH2_CNT_SUB,
            `SIB_DMA_CH2_SYNC_SUB,
            `SIB_DMA_CH2_MODE_SUB,
            `SIB_DMA_CH3_SRC_SUB,
            `SIB_DMA_CH3_DST_SUB,
            `SIB_DMA_CH3_CNT_SUB,
            `SIB_DMA_CH3_SYNC_SUB,
            `SIB_DMA_CH3_MODE_SUB,
            `SIB_DMA_CH4_SRC_SUB,
            `SIB_DMA_CH4_DST_SUB,
            `SIB_DMA_CH4_CNT_SUB,
            `SIB_DMA_CH4_SYNC_SUB,
            `SIB_DMA_CH4_MODE_SUB,
            `SIB_DMA_CH5_SRC_SUB,
            `SIB_DMA_CH5_DST_SUB,
            `SIB_DMA_CH5_CNT_SUB,
            `SIB_DMA_CH5_SYNC_SUB,
            `SIB_DMA_CH5_MODE_SUB,
            `SIB_DMA_SRC_PAGE_SUB,
            `SIB_DMA_DST_PAGE_SUB,
            `SIB_DMA_ELEM_IDX0_SUB,
            `SIB_DMA_ELEM_IDX1_SUB,
            `SIB_DMA_FRAME_IDX0_SUB,
            `SIB_DMA_FRAME_IDX1_SUB,
            `SIB_DMA_RELOAD_SUB,
            `SIB_DMA_RLD0_DST_SUB,
            `SIB_DMA_RLD0_CNT_SUB,
            `SIB_DMA_RLD0_FRM_SUB,
            `SIB_DMA_XSRC_PAGE_SUB,
            `SIB_DMA_XDST_PAGE_SUB,
            `SIB_DMA_RLD1_SRC_SUB,
            `SIB_DMA_RLD1_DST_SUB,
            `SIB_DMA_RLD1_CNT_SUB,
            `SIB_DMA_RLD1_FRM_SUB,
            `SIB_DMA_RLD2_SRC_SUB,
            `SIB_DMA_RLD2_DST_SUB,
            `SIB_DMA_RLD2_CNT_SUB,
            `SIB_DMA_RLD2_FRM_SUB,
            `SIB_DMA_RLD3_SRC_SUB,
            `SIB_DMA_RLD3_DST_SUB,
            `SIB_DMA_RLD3_CNT_SUB,
            `SIB_DMA_RLD3_FRM_SUB,
            `SIB_DMA_RLD4_SRC_SUB,
            `SIB_DMA_RLD4_DST_SUB,
            `SIB_DMA_RLD4_CNT_SUB,
            `SIB_DMA_RLD4_FRM_SUB,
            `SIB_DMA_RLD5_SRC_SUB,
            `SIB_DMA_RLD5_DST_SUB,
            `SIB_DMA_RLD5_CNT_SUB,
            `SIB_DMA_RLD5_FRM_SUB: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction

    // DMA storage follows the subaddress one to one.
    function automatic logic [5:0] dma_slot(input logic [15:0] p);
        case (p)
            `SIB_DMA_CH0_SRC_SUB: return 6'h00;
            `SIB_DMA_CH0_DST_SUB: return 6'h01;
            `SIB_DMA_CH0_CNT_SUB: return 6'h02;
            `SIB_DMA_CH0_SYNC_SUB: return 6'h03;
            `SIB_DMA_CH0_MODE_SUB: return 6'h04;
            `SIB_DMA_CH1_SRC_SUB: return 6'h05;
            `SIB_DMA_CH1_DST_SUB: return 6'h06;
            `SIB_DMA_CH1_CNT_SUB: return 6'h07;
            `SIB_DMA_CH1_SYNC_SUB: return 6'h08;
            `SIB_DMA_CH1_MODE_SUB: return 6'h09;
            `SIB_DMA_CH2_SRC_SUB: return 6'h0a;
            `SIB_DMA_CH2_DST_SUB: return 6'h0b;
            `SIB_DMA_CH2_CNT_SUB: return 6'h0c;
            `SIB_DMA_CH2_SYNC_SUB: return 6'h0d;
            `SIB_DMA_CH2_MODE_SUB: return 6'h0e;
            `SIB_DMA_CH3_SRC_SUB: return 6'h0f;
            `SIB_DMA_CH3_DST_SUB: return 6'h10;
            `SIB_DMA_CH3_CNT_SUB: return 6'h11;
            `SIB_DMA_CH3_SYNC_SUB: return 6'h12;
            `SIB_DMA_CH3_MODE_SUB: return 6'h13;
            `SIB_DMA_CH4_SRC_SUB: return 6'h14;
            `SIB_DMA_CH4_DST_SUB: return 6'h15;
            `SIB_DMA_CH4_CNT_SUB: return 6'h16;
            `SIB_DMA_CH4_SYNC_SUB: return 6'h17;
            `SIB_DMA_CH4_MODE_SUB: return 6'h18;
            `SIB_DMA_CH5_SRC_SUB: return 6'h19;
            `SIB_DMA_CH5_DST_SUB: return 6'h1a;
            `SIB_DMA_CH5_CNT_SUB: return 6'h1b;
            `SIB_DMA_CH5_SYNC_SUB: return 6'h1c;
            `SIB_DMA_CH5_MODE_SUB: return 6'h1d;
            `SIB_DMA_SRC_PAGE_SUB: return 6'h1e;
            `SIB_DMA_DST_PAGE_SUB: return 6'h1f;
            `SIB_DMA_ELEM_IDX0_SUB: return 6'h20;
            `SIB_DMA_ELEM_IDX1_SUB: return 6'h21;
            `SIB_DMA_FRAME_IDX0_SUB: return 6'h22;
            `SIB_DMA_FRAME_IDX1_SUB: return 6'h23;
            `SIB_DMA_RELOAD_SUB: return 6'h24;
            `SIB_DMA_RLD0_DST_SUB: return 6'h25;
            `SIB_DMA_RLD0_CNT_SUB: return 6'h26;
            `SIB_DMA_RLD0_FRM_SUB: return 6'h27;
            `SIB_DMA_XSRC_PAGE_SUB: return 6'h28;
            `SIB_DMA_XDST_PAGE_SUB: return 6'h29;
            `SIB_DMA_RLD1_SRC_SUB: return 6'h2a;
            `SIB_DMA_RLD1_DST_SUB: return 6'h2b;
            `SIB_DMA_RLD1_CNT_SUB: return 6'h2c;
            `SIB_DMA_RLD1_FRM_SUB: return 6'h2d;
            `SIB_DMA_RLD2_SRC_SUB: return 6'h2e;
            `SIB_DMA_RLD2_DST_SUB: return 6'h2f;
            `SIB_DMA_RLD2_CNT_SUB: return 6'h30;
            `SIB_DMA_RLD2_FRM_SUB: return 6'h31;
            `SIB_DMA_RLD3_SRC_SUB: return 6'h32;
            `SIB_DMA_RLD3_DST_SUB: return 6'h33;
            `SIB_DMA_RLD3_CNT_SUB: return 6'h34;
            `SIB_DMA_RLD3_FRM_SUB: return 6'h35;
            `SIB_DMA_RLD4_SRC_SUB: return 6'h36;
            `SIB_DMA_RLD4_DST_SUB: return 6'h37;
            `SIB_DMA_RLD4_CNT_SUB: return 6'h38;
            `SIB_DMA_RLD4_FRM_SUB: return 6'h39;
            `SIB_DMA_RLD5_SRC_SUB: return 6'h3a;
            `SIB_DMA_RLD5_DST_SUB: return 6'h3b;
            `SIB_DMA_RLD5_CNT_SUB: return 6'h3c;
            `SIB_DMA_RLD5_FRM_SUB: return 6'h3d;
            default: return 6'h00;
        endcase
    endfunction

    // ==========================================================
    // State and next state.
    // ==========================================================
    sib_state_t s;
    sib_state_t next_s;
    sib_port_t pd;
    sib_port_t pp;
    logic [15:0] rd_word;
    logic [15:0] sp_sel;
    logic sp_hit;
    logic [4:0] sp_idx;
    logic dma_hit;
    logic [5:0] dma_idx;

    // ==========================================================
    // Read multiplexer and write steering.
    // ==========================================================
    always_comb begin
        next_s = s;
        rd_word = 16'h0000;
        pd = sp_data_sel(req.addr);
        pp = sp_ptr_sel(req.addr);
        sp_sel = 16'h0000;
        if (pd != SIB_PORT_NONE) begin
            sp_sel = s.sp_ptr[pd];
        end
        sp_hit = sp_sub_ok(sp_sel);
        sp_idx = sp_slot(sp_sel);
        dma_hit = dma_sub_ok(s.dma_ptr);
        dma_idx = dma_slot(s.dma_ptr);
        // Writes reach only the decoded location; unmapped ones read zero.
        case (req.addr)
            `SIB_SP0_PTR_ADDR,
            `SIB_SP1_PTR_ADDR,
            `SIB_SP2_PTR_ADDR: begin
                rd_word = s.sp_ptr[pp];
                if (req.wr) begin
                    next_s.sp_ptr[pp] = req.wdata;
                end
            end
            `SIB_SP0_DATA_ADDR,
            `SIB_SP1_DATA_ADDR,
            `SIB_SP2_DATA_ADDR: begin
                if (sp_hit) begin
                    rd_word = s.sp_reg[pd][sp_idx];
                    if (req.wr) begin
                        next_s.sp_reg[pd][sp_idx] = req.wdata;
                    end
                end
            end
            `SIB_DMA_PRIO_ADDR: begin
                rd_word = s.dma_prio;
                if (req.wr) begin
                    next_s.dma_prio = req.wdata;
                end
            end
            `SIB_DMA_PTR_ADDR: begin
                rd_word = s.dma_ptr;
                if (req.wr) begin
                    next_s.dma_ptr = req.wdata;
                end
            end
            `SIB_DMA_AUTOINC_ADDR,
            `SIB_DMA_PLAIN_ADDR: begin
                if (dma_hit) begin
                    rd_word = s.dma_reg[dma_idx];
                    if (req.wr) begin
                        next_s.dma_reg[dma_idx] = req.wdata;
                    end
                end
            end
            default: begin
                rd_word = 16'h0000;
            end
        endcase
        // Post-increment after any access through the auto-increment port.
        if ((req.rd || req.wr) && req.addr == `SIB_DMA_AUTOINC_ADDR) begin
            next_s.dma_ptr = s.dma_ptr + 16'h0001;
        end
        next_s.rsp.valid = req.rd;
        next_s.rsp.data = req.rd ? rd_word : 16'h0000;
    end

    // ==========================================================
    // State register.
    // ==========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs straight from the state flip-flops.
    // ==========================================================
    assign rsp = s.rsp;
    assign dma_prio = s.dma_prio;
    assign dma_ptr = s.dma_ptr;
endmodule // sib_regbank
`default_nettype wire

//--- sib_regbank_sva.sv
// Port assertions for the subbank register block.
`timescale 1ns/1ps
`default_nettype none
module sib_regbank_sva (
    input wire logic clk,
    input wire logic rst,
    input wire sib_pkg::sib_req_t req,
    input wire sib_pkg::sib_rsp_t rsp,
    input wire logic [15:0] dma_prio,
    input wire logic [15:0] dma_ptr
);
    import sib_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_auto;
        (req.rd || req.wr) && req.addr == 8'h56;
    endsequence
    chk_rd_answer: assert property (req.rd |=> rsp.valid)
        else $error("read not answered");
    chk_idle_quiet: assert property (!req.rd |=> !rsp.valid && rsp.data == 0)
        else $error("answer without read");
    chk_ptr_bump: assert property (s_auto |=> dma_ptr == $past(dma_ptr) + 16'h0001)
        else $error("pointer not advanced");
    chk_ptr_keep: assert property (!(req.rd || req.wr) || req.addr == 8'h57 |=> $stable(dma_ptr))
        else $error("pointer moved");
    chk_ptr_load: assert property (req.wr && req.addr == 8'h55 |=> dma_ptr == $past(req.wdata))
        else $error("pointer not loaded");
    chk_ptr_read: assert property (req.rd && req.addr == 8'h55 |=> rsp.data == $past(dma_ptr))
        else $error("pointer read wrong");
    chk_prio_load: assert property (req.wr && req.addr == 8'h54 |=> dma_prio == $past(req.wdata))
        else $error("priority not loaded");
    chk_prio_keep: assert property (!(req.wr && req.addr == 8'h54) |=> $stable(dma_prio))
        else $error("priority moved");
endmodule // sib_regbank_sva
bind sib_regbank sib_regbank_sva sib_regbank_sva_i (.clk(clk), .rst(rst),
    .req(req), .rsp(rsp), .dma_prio(dma_prio), .dma_ptr(dma_ptr));
`default_nettype wire

//--- test_subbank_indirect_register_access.sv
// Self-checking bench for the subbank register block.
`timescale 1ns/1ps
`default_nettype none
module test_subbank_indirect_register_access;
    import sib_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    sib_req_t req = '0;
    sib_rsp_t rsp;
    logic [15:0] dma_prio, dma_ptr, dp = '0, prio = '0;
    logic [15:0] msp [3][32] = '{default: '0};
    logic [15:0] mdm [64] = '{default: '0};
    logic [15:0] spp [3] = '{default: '0};
    logic [7:0] ap [3] = '{8'h38, 8'h48, 8'h34};
    logic [15:0] exp_q [$];
    logic [31:0] seed = 32'd81552;
    int fail_count = 0;
    int n_checks = 0;
    always #5 clk = ~clk;
    sib_regbank sib_regbank_i (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
        .dma_prio(dma_prio), .dma_ptr(dma_ptr));
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        n_checks++;
        if (g !== x) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic acc(input logic r, w, input logic [7:0] a, input logic [15:0] d);
        logic [15:0] e;
        e = 16'h0000;
        for (int p = 0; p < 3; p++) begin
            if (a == ap[p]) e = spp[p];
            if (a == ap[p] && w) spp[p] = d;
            if (a == ap[p] + 8'h01 && spp[p] < 28 && spp[p] != 15) begin
                e = msp[p][spp[p][4:0]];
                if (w) msp[p][spp[p][4:0]] = d;
            end
        end
        if (a == 8'h54) e = prio;
        if (a == 8'h54 && w) prio = d;
        if (a == 8'h55) e = dp;
        if ((a == 8'h56 || a == 8'h57) && dp < 62) e = mdm[dp[5:0]];
        if ((a == 8'h56 || a == 8'h57) && dp < 62 && w) mdm[dp[5:0]] = d;
        if (a == 8'h55 && w) dp = d;
        if (a == 8'h56) dp = dp + 16'h0001;
        if (r) exp_q.push_back(e);
        req <= '{rd: r, wr: w, addr: a, wdata: d};
        @(posedge clk);
    endtask
    task automatic chk_dma();
        req <= '0;
        #1 chk(dma_ptr, dp);
        chk(dma_prio, prio);
        @(posedge clk);
    endtask
    always @(posedge clk) if (rsp.valid === 1'b1) begin
        if (exp_q.size() == 0) begin
            fail_count++;
            $display("wrong value at %0t: answer without read", $time);
        end else begin
            chk(rsp.data, exp_q.pop_front());
        end
    end
    initial begin
        #50us;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int ph = 0; ph < 2; ph++) for (int p = 0; p < 3; p++) begin
            for (int s = 0; s < 32; s++) begin
                acc(0, 1, ap[p], s[15:0]);
                acc(ph == 1, ph == 0 || s == 5, ap[p] + 8'h01, rnd());
            end
        end
        $display("serial test done");
        acc(0, 1, 8'h55, 16'h0000);
        for (int s = 0; s < 64; s++) acc(0, 1, 8'h56, rnd());
        chk_dma();
        acc(1, 1, 8'h55, 16'h0000);
        for (int s = 0; s < 64; s++) acc(1, 0, 8'h56, 16'h0000);
        acc(0, 1, 8'h55, 16'h0021);
        repeat (3) acc(1, 1, 8'h57, rnd());
        chk_dma();
        acc(0, 1, 8'h54, rnd());
        acc(1, 0, 8'h54, 16'h0000);
        acc(1, 1, 8'h55, 16'hffff);
        acc(1, 0, 8'h56, 16'h0000);
        acc(1, 0, 8'h36, 16'h0000);
        chk_dma();
        req <= '0;
        repeat (3) @(posedge clk);
        chk(16'(exp_q.size()), 16'h0000);
        $display("dma test done");
        print_verdict();
    end
endmodule // test_subbank_indirect_register_access
`default_nettype wire
